// ---- hdl/primary_gate_ctrl_regs.sv ----
// primary-side plateau and verification select control registers
`timescale 1ns/1ps
module primary_gate_ctrl_regs (
  input wire logic sys_clk, // register clock
  input wire logic rst, // asynchronous reset, active high
  input gate_regs_pkg::reg_req_t regReq, // frame decoder request
  input gate_regs_pkg::mode_evt_t modeEvt, // mode entry strobes
  input wire logic msgInvalid, // 1 = current frame discarded
  output logic [15:0] rdData_q, // registered response word
  output logic [3:0] plateauLevel_q, // plateau code to the driver stage
  output logic clkSupActive_q // clock supervision armed
);
  import gate_regs_pkg::*;

  // the payload wiring below assumes these layouts; refuse fields that do not end at bits 5 and 3
  if (PLATEAU_LSB + PLATEAU_W != 6) begin : gPlateauLayout
    $error("plateau field must end at bit 5");
  end
  if (VFS_LSB + VFS_W != 4) begin : gVerifLayout
    $error("selection field must end at bit 3");
  end
  // flag and parity are packed by position in the word builder
  if (INVALID_BIT != 1 || PARITY_BIT != 0) begin : gStatusLayout
    $error("status bits must sit at bits 1 and 0");
  end

  // stored fields and their next values
  logic [3:0] plateauLevel_d; // level after this edge
  logic [1:0] verifSel_q; // stored selection, acted on at self-test only
  logic [1:0] verifSel_d; // selection after this edge
  logic clkSupActive_d; // armed state after this edge
  logic lastInvalid_q; // fate of the previous frame, 1 = discarded
  logic lastInvalid_d; // flag after this edge
  logic [15:0] rdData_d; // response word after this edge

  // a strobe of either kind closes one host frame
  wire anyStrobe = regReq.wrEn || regReq.rdEn;
  // address decode of the two mapped words
  wire hitPlateau = regReq.addr == PLATEAU_CTRL_OFS; // plateau word
  wire hitVerif = regReq.addr == VERIF_SEL_OFS; // selection word
  // a discarded frame must never reach the storage
  wire wrPlateau = regReq.wrEn && hitPlateau && !msgInvalid;
  wire wrVerif = regReq.wrEn && hitVerif && !msgInvalid;

  // mode entries; initial mode wins if both fire in one cycle
  wire clearSel = modeEvt.enterInitial;
  wire armNow = modeEvt.enterSelfTest && !modeEvt.enterInitial;
  // only code 10 arms; 00 and the reserved codes leave it idle
  wire selIsClkSup = verifSel_q == VFS_CLK_SUP;

  // written fields; every other written bit is dropped here
  wire [3:0] plateauWrField =
    regReq.wdata[PLATEAU_LSB +: PLATEAU_W];
  wire [1:0] verifWrField = regReq.wdata[VFS_LSB +: VFS_W];

  // response payloads; bits above each field always read as zero
  wire [13:0] plateauPayload = {10'h000, plateauLevel_q};
  wire [13:0] verifPayload = {12'h000, verifSel_q};
  wire [15:0] plateauWord; // plateau response word
  wire [15:0] verifWord; // selection response word
  wire [15:0] zeroWord; // response for an unmapped offset

  // rebuild each response word with flag and parity
  odd_parity_word #(.W(16)) uPlat (
    .payload(plateauPayload),
    .lastInvalid(lastInvalid_q),
    .word(plateauWord)
  );
  odd_parity_word #(.W(16)) uVerif (
    .payload(verifPayload),
    .lastInvalid(lastInvalid_q),
    .word(verifWord)
  );
  odd_parity_word #(.W(16)) uZero (
    .payload(14'h0000),
    .lastInvalid(lastInvalid_q),
    .word(zeroWord)
  );

  // word of the addressed register; unmapped offsets give flag and parity
  wire [15:0] selWord = hitPlateau ? plateauWord :
    (hitVerif ? verifWord : zeroWord);

  // plateau level is plain storage
  assign plateauLevel_d = wrPlateau ? plateauWrField : plateauLevel_q;

  // initial-mode clear wins over a host write in the same cycle
  assign verifSel_d = clearSel ? VFS_NONE :
    (wrVerif ? verifWrField : verifSel_q);

  // arming reads the stored code, not a write landing in the same cycle,
  // so a host cannot race a new selection into an entry already under way
  assign clkSupActive_d = clearSel ? 1'b0 :
    (armNow ? selIsClkSup : clkSupActive_q);

  // every frame end records its own fate for the following response
  assign lastInvalid_d = anyStrobe ? msgInvalid : lastInvalid_q;

  // the response is built from state before the read edge, so it carries
  // the flag of the frame ahead of this read
  assign rdData_d = regReq.rdEn ? selWord : rdData_q;

  // plateau level register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      plateauLevel_q <= PLATEAU_LEVEL_RST; // reset code 1111
    end else begin
      plateauLevel_q <= plateauLevel_d;
    end
  end

  // selection register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      verifSel_q <= VERIF_SEL_RST[VFS_LSB +: VFS_W]; // no function
    end else begin
      verifSel_q <= verifSel_d;
    end
  end

  // armed state of clock supervision
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clkSupActive_q <= 1'b0; // nothing armed out of reset
    end else begin
      clkSupActive_q <= clkSupActive_d;
    end
  end

  // last-message flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lastInvalid_q <= 1'b0; // no frame seen yet
    end else begin
      lastInvalid_q <= lastInvalid_d;
    end
  end

  // registered response word; it holds until the next read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdData_q <= 16'h0000; // no response before the first read
    end else begin
      rdData_q <= rdData_d;
    end
  end

  // plateau storage: accepted writes land, all else leaves it alone
  plateau_write_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    wrPlateau |=> plateauLevel_q == $past(regReq.wdata[5:2]))
    else $error("plateau level not stored");
  plateau_hold_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !wrPlateau |=> $stable(plateauLevel_q))
    else $error("plateau level changed without a write");

  // last-message flag: recorded per frame, shown in the next response
  flag_follows_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (regReq.wrEn || regReq.rdEn) |=> lastInvalid_q == $past(msgInvalid))
    else $error("invalid flag wrong");
  read_flag_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    regReq.rdEn |=> rdData_q[1] == $past(lastInvalid_q))
    else $error("response flag wrong");

  // response word: odd parity, stands until the next read
  read_parity_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    $past(regReq.rdEn) |-> ^rdData_q == 1'b1)
    else $error("read word not odd parity");
  read_hold_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !regReq.rdEn |=> $stable(rdData_q))
    else $error("response changed without a read");

  // selection decode: only code 10 arms supervision
  reserved_noarm_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (modeEvt.enterSelfTest && !modeEvt.enterInitial
     && verifSel_q != VFS_CLK_SUP) |=> !clkSupActive_q)
    else $error("reserved code armed supervision");

  // arming happens at self-test entry and nowhere else
  selftest_arm_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!modeEvt.enterSelfTest && !modeEvt.enterInitial) |=>
    $stable(clkSupActive_q))
    else $error("supervision changed outside mode entry");
  sup_arm_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (modeEvt.enterSelfTest && !modeEvt.enterInitial
     && verifSel_q == VFS_CLK_SUP) |=> clkSupActive_q)
    else $error("supervision not armed at self-test entry");

  // initial-mode entry clears selection and armed state
  initial_clear_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    modeEvt.enterInitial |=> verifSel_q == VFS_NONE && !clkSupActive_q)
    else $error("initial mode did not clear");

  // selection storage: accepted writes land, all else except initial-mode entry leaves it alone
  verif_write_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (wrVerif && !modeEvt.enterInitial) |=>
    verifSel_q == $past(regReq.wdata[3:2]))
    else $error("selection not stored");
  verif_hold_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!wrVerif && !modeEvt.enterInitial) |=> $stable(verifSel_q))
    else $error("selection changed without a write");

  // unused upper bits always read as zero
  upper_zero_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    $past(regReq.rdEn) |-> rdData_q[15:6] == 10'h000)
    else $error("upper bits not zero");
  verif_upper_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (regReq.rdEn && hitVerif) |=> rdData_q[15:4] == 12'h000)
    else $error("selection word upper bits not zero");
endmodule

// ---- hdl/gate_regs_pkg.sv ----
// package: offsets, field layouts, reset values for the gate control registers
package gate_regs_pkg;
  localparam logic [7:0] PLATEAU_CTRL_OFS = 8'h07;
  localparam logic [7:0] VERIF_SEL_OFS = 8'h08;
  localparam logic [15:0] PLATEAU_CTRL_RST = 16'h003d;
  localparam logic [15:0] VERIF_SEL_RST = 16'h0001;
  localparam int PLATEAU_LSB = 2;
  localparam int PLATEAU_W = 4;
  localparam int VFS_LSB = 2;
  localparam int VFS_W = 2;
  localparam int INVALID_BIT = 1;
  localparam int PARITY_BIT = 0;
  localparam logic [3:0] PLATEAU_LEVEL_RST = 4'hf;
  localparam logic [1:0] VFS_NONE = 2'h0;
  localparam logic [1:0] VFS_CLK_SUP = 2'h2;

  // register access request from the serial frame decoder
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  // operating mode entry strobes from the mode controller
  typedef struct packed {
    logic enterInitial;
    logic enterSelfTest;
  } mode_evt_t;
endpackage

// ---- hdl/odd_parity_word.sv ----
// combines a 14-bit payload, invalid flag and odd parity into a word
`timescale 1ns/1ps
module odd_parity_word #(
  parameter int W = 16
) (
  input wire logic [W-3:0] payload,
  input wire logic lastInvalid,
  output logic [W-1:0] word
);
  // the word needs room for at least one payload bit besides flag and parity
  if (W < 3) begin : gWidthCheck
    $error("odd_parity_word: width too small");
  end
  // parity bit makes the whole word odd, flag included
  assign word = {payload, lastInvalid, ~(^{payload, lastInvalid})};
endmodule

// ---- bench/host_model.sv ----
// host model issuing one register frame at a time
`timescale 1ns/1ps
module host_model
  import gate_regs_pkg::*;
(
  input wire logic sys_clk,
  output gate_regs_pkg::reg_req_t req,
  output logic bad
);
  initial begin
    req = '0;
    bad = 1'b0;
  end
  // strobe stands one edge; released lines invert so stale data never helps
  task automatic xfer(logic wr, logic [7:0] a, logic [15:0] d, logic inv);
    @(negedge sys_clk);
    req = '{wrEn: wr, rdEn: ~wr, addr: a, wdata: d};
    bad = inv;
    @(negedge sys_clk);
    req = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: ~d};
    bad = ~inv;
  endtask
endmodule

// ---- bench/primary_gate_ctrl_regs_bench.sv ----
// self-checking bench for the gate control registers
`timescale 1ns/1ps
module primary_gate_ctrl_regs_bench;
  import gate_regs_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  mode_evt_t modeEvt = '0;
  reg_req_t regReq;
  logic msgInvalid;
  logic [15:0] rdData_q;
  logic [3:0] plateauLevel_q;
  logic clkSupActive_q;
  int num_errors = 0;
  int total_checks = 0;
  always #50 sys_clk = ~sys_clk;
  host_model u_host(.sys_clk(sys_clk), .req(regReq), .bad(msgInvalid));
  primary_gate_ctrl_regs u_dut(.sys_clk(sys_clk), .rst(rst),
    .regReq(regReq), .modeEvt(modeEvt), .msgInvalid(msgInvalid),
    .rdData_q(rdData_q), .plateauLevel_q(plateauLevel_q),
    .clkSupActive_q(clkSupActive_q));
  // expected word: payload, flag, odd parity over the whole word
  function automatic logic [15:0] word(logic [15:0] p, logic f);
    return {p[15:2], f, ~^{p[15:2], f}};
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // read data stands until the next read, so sample a full cycle later
  task automatic rd(logic [7:0] a, logic [15:0] exp);
    u_host.xfer(1'b0, a, 16'h0000, 1'b0);
    @(negedge sys_clk);
    chk(rdData_q, exp);
  endtask
  task automatic pulse(logic init);
    @(negedge sys_clk);
    modeEvt = '{enterInitial: init, enterSelfTest: ~init};
    @(negedge sys_clk);
    modeEvt = '0;
  endtask
  task automatic t_reset();
    rd(8'h07, 16'h003d);
    rd(8'h08, 16'h0001);
    chk({15'h0000, clkSupActive_q}, 16'h0000);
    $display("reset test done");
  endtask
  // every level code, with upper and status bits written as ones
  task automatic t_plateau();
    for (int i = 0; i < 16; i++) begin
      u_host.xfer(1'b1, 8'h07, 16'hffc3 | 16'(i << 2), 1'b0);
      chk({12'h000, plateauLevel_q}, 16'(i));
      rd(8'h07, word(16'(i << 2), 1'b0));
    end
    $display("plateau test done");
  endtask
  // a discarded frame stores nothing and raises the flag once
  task automatic t_invalid();
    u_host.xfer(1'b1, 8'h07, 16'h0008, 1'b1);
    chk({12'h000, plateauLevel_q}, 16'h000f);
    rd(8'h07, word(16'h003c, 1'b1));
    rd(8'h07, word(16'h003c, 1'b0));
    rd(8'h09, word(16'h0000, 1'b0));
    $display("invalid test done");
  endtask
  // store, arm on self-test entry, hold over writes, clear on initial
  task automatic t_select();
    u_host.xfer(1'b1, 8'h08, 16'hfffa, 1'b0);
    rd(8'h08, word(16'h0008, 1'b0));
    chk({15'h0000, clkSupActive_q}, 16'h0000);
    pulse(1'b0);
    chk({15'h0000, clkSupActive_q}, 16'h0001);
    u_host.xfer(1'b1, 8'h08, 16'h0000, 1'b0);
    chk({15'h0000, clkSupActive_q}, 16'h0001);
    rd(8'h08, 16'h0001);
    u_host.xfer(1'b1, 8'h08, 16'h0008, 1'b0);
    pulse(1'b1);
    chk({15'h0000, clkSupActive_q}, 16'h0000);
    rd(8'h08, 16'h0001);
    pulse(1'b0);
    chk({15'h0000, clkSupActive_q}, 16'h0000);
    // a host write in the very cycle of initial entry loses to the clear
    fork
      u_host.xfer(1'b1, 8'h08, 16'h0008, 1'b0);
      pulse(1'b1);
    join
    rd(8'h08, 16'h0001);
    u_host.xfer(1'b1, 8'h08, 16'h0008, 1'b0);
    u_host.xfer(1'b1, 8'h08, 16'hfff3, 1'b0);
    pulse(1'b0);
    chk({15'h0000, clkSupActive_q}, 16'h0000);
    rd(8'h08, 16'h0001);
    $display("select test done");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_plateau();
    t_invalid();
    t_select();
    conclude();
  end
  // the tests need about 150 cycles; far beyond that means a hang
  initial begin
    #100us;
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    conclude();
  end
endmodule
